// ==== src/ioec_pkg.sv ====
// Package for the isochronous out endpoint configuration byte block.
// Assumes a single system clock and a plain address/strobe register port.
package ioec_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [3:0] CFG_OFFS = 4'h0;
    localparam logic [3:0] STAT_OFFS = 4'h1;
    localparam logic [3:0] LIMIT_OFFS = 4'h2;
    // Field positions of the configuration byte
    localparam int ON_BIT = 7;
    localparam int ISO_BIT = 6;
    localparam int OVR_BIT = 5;
    localparam int SIZE_MSB = 4;
    localparam int SIZE_W = 5;
    // Reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'h80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Endpoint handling mode
    typedef enum logic [1:0] {
        IOEC_MODE_OFF = 2'h0,
        IOEC_MODE_NONISO = 2'h1,
        IOEC_MODE_ISO = 2'h3
    } ioec_mode_type;
    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ioec_req_type;
    // Incoming data byte from the serial engine
    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic pkt_start;
    } ioec_byte_type;
endpackage : ioec_pkg

// ==== src/ioec_buf_writer.sv ====
// Buffer manager write side for the isochronous out endpoint.
// Assumes bytes arrive one per cycle, synchronous to clk, framed by pkt_start.
module ioec_buf_writer #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire ioec_pkg::ioec_byte_type in_byte,
    input wire logic [CNT_W-1:0] limit,
    input wire logic [4:0] sample_bytes_m1,
    output logic wr_en,
    output logic [CNT_W-1:0] wr_addr,
    output logic [7:0] wr_data,
    output logic overflow,
    output logic sample_end
);
    initial begin
        if (CNT_W < 6) $error("CNT_W too small");
    end
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [4:0] smp_ff, nxt_smp;
    logic wr_en_ff, ovf_ff, send_ff;
    logic [CNT_W-1:0] addr_ff;
    logic [7:0] data_ff;
    wire [CNT_W-1:0] base = in_byte.pkt_start ? '0 : cnt_ff;
    wire [4:0] sbase = in_byte.pkt_start ? 5'h00 : smp_ff;
    wire take = active && in_byte.valid;
    // Overflow: byte would land at or past the allotted space
    wire full = (base >= limit);
    wire accept = take && !full;
    wire smp_done = accept && (sbase == sample_bytes_m1);
    // Counters next values
    assign nxt_cnt = accept ? CNT_W'(base + 1'b1) : base;
    assign nxt_smp = smp_done ? 5'h00 : (accept ? sbase + 5'h01 : sbase);
    // Counters and registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
            smp_ff <= 5'h00;
            wr_en_ff <= 1'b0;
            addr_ff <= '0;
            data_ff <= 8'h00;
            ovf_ff <= 1'b0;
            send_ff <= 1'b0;
        end else begin
            cnt_ff <= (take || in_byte.pkt_start) ? nxt_cnt : cnt_ff;
            smp_ff <= (take || in_byte.pkt_start) ? nxt_smp : smp_ff;
            wr_en_ff <= accept;
            addr_ff <= base;
            data_ff <= in_byte.data;
            ovf_ff <= take && full;
            send_ff <= smp_done;
        end
    end
    assign wr_en = wr_en_ff;
    assign wr_addr = addr_ff;
    assign wr_data = data_ff;
    assign overflow = ovf_ff;
    assign sample_end = send_ff;
endmodule : ioec_buf_writer

// ==== src/ioec_endpoint.sv ====
// Isochronous out endpoint configuration byte with its buffer write side.
// Assumes firmware on the register port and the serial engine on in_byte, one clock.
// Functional notes
// - Endpoint active only while firmware holds bit 7 at one.
// - Bit 6 one selects isochronous handling, zero control/interrupt/bulk.
// - Buffer manager sets overrun bit 5 on buffer overflow.
// - Overrun stays set until firmware writes zero; does not alter operation.
// - Bits 4:0 give one less than the bytes of one full codec frame sample.
//
// Strobed register access and the register addresses were chosen for this implementation.
module ioec_endpoint #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire ioec_pkg::ioec_req_type req,
    output logic [ioec_pkg::DATA_W-1:0] rdata,
    input wire ioec_pkg::ioec_byte_type in_byte,
    output logic iso_active,
    output logic noniso_active,
    output logic [5:0] sample_bytes,
    output logic buf_wr_en,
    output logic [CNT_W-1:0] buf_wr_addr,
    output logic [7:0] buf_wr_data,
    output logic sample_end
);
    initial begin
        if (CNT_W > ioec_pkg::DATA_W) $error("CNT_W must fit a register byte");
    end
    logic [7:0] cfg_ff, nxt_cfg;
    logic [7:0] limit_ff;
    logic [7:0] rdata_ff, nxt_rdata;
    logic ovf_pulse;
    logic [CNT_W-1:0] bytes_seen_ff;
    ioec_pkg::ioec_mode_type mode;

    // Address decode
    wire sel_cfg = req.addr == ioec_pkg::CFG_OFFS;
    wire sel_stat = req.addr == ioec_pkg::STAT_OFFS;
    wire sel_lim = req.addr == ioec_pkg::LIMIT_OFFS;
    wire wr_cfg = req.wr && sel_cfg;
    wire wr_lim = req.wr && sel_lim;

    // Field views
    wire ep_on = cfg_ff[ioec_pkg::ON_BIT];
    wire ep_iso = cfg_ff[ioec_pkg::ISO_BIT];
    wire [4:0] size_m1 = cfg_ff[ioec_pkg::SIZE_MSB:0];
    assign mode = !ep_on ? ioec_pkg::IOEC_MODE_OFF :
                  (ep_iso ? ioec_pkg::IOEC_MODE_ISO : ioec_pkg::IOEC_MODE_NONISO);
    assign iso_active = mode == ioec_pkg::IOEC_MODE_ISO;
    assign noniso_active = mode == ioec_pkg::IOEC_MODE_NONISO;
    assign sample_bytes = {1'b0, size_m1} + 6'h01;

    // Next config: overrun set beats a firmware clear in the same cycle
    always_comb begin
        nxt_cfg = wr_cfg ? req.wdata : cfg_ff;
        if (ovf_pulse) begin
            nxt_cfg[ioec_pkg::OVR_BIT] = 1'b1;
        end
    end

    // Read mux: status holds a count of bytes seen in current packet
    always_comb begin
        nxt_rdata = ioec_pkg::ZERO_BYTE;
        if (sel_cfg) begin
            nxt_rdata = cfg_ff;
        end else if (sel_stat) begin
            nxt_rdata[CNT_W-1:0] = bytes_seen_ff;
        end else if (sel_lim) begin
            nxt_rdata = limit_ff;
        end
    end

    // Register storage; hardware never clears the overrun bit
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff <= ioec_pkg::CFG_RST;
            limit_ff <= ioec_pkg::LIMIT_RST;
            rdata_ff <= ioec_pkg::ZERO_BYTE;
        end else begin
            cfg_ff <= nxt_cfg;
            limit_ff <= wr_lim ? req.wdata : limit_ff;
            rdata_ff <= req.rd ? nxt_rdata : ioec_pkg::ZERO_BYTE;
        end
    end
    assign rdata = rdata_ff;

    // Packet byte tally, purely observational; a first byte on pkt_start counts too
    always_ff @(posedge clk) begin
        if (rst) begin
            bytes_seen_ff <= '0;
        end else if (in_byte.pkt_start) begin
            bytes_seen_ff <= {{(CNT_W-1){1'b0}}, iso_active && in_byte.valid};
        end else if (iso_active && in_byte.valid && (&bytes_seen_ff == 1'b0)) begin
            bytes_seen_ff <= CNT_W'(bytes_seen_ff + 1'b1);
        end
    end

    // Write side sees enable, mode and the size field, never the overrun bit
    ioec_buf_writer #(
        .CNT_W(CNT_W)
    ) u_writer (
        .clk(clk),
        .rst(rst),
        .active(iso_active),
        .in_byte(in_byte),
        .limit(limit_ff[CNT_W-1:0]),
        .sample_bytes_m1(size_m1),
        .wr_en(buf_wr_en),
        .wr_addr(buf_wr_addr),
        .wr_data(buf_wr_data),
        .overflow(ovf_pulse),
        .sample_end(sample_end)
    );
endmodule : ioec_endpoint

// ==== tb/ioec_endpoint_properties.sv ====
// Checker for the out endpoint configuration byte.
// Assumes a bind onto ioec_endpoint; sees its ports only.
module ioec_endpoint_chk #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire ioec_pkg::ioec_req_type req,
    input wire logic [7:0] rdata,
    input wire ioec_pkg::ioec_byte_type in_byte,
    input wire logic iso_active,
    input wire logic noniso_active,
    input wire logic [5:0] sample_bytes,
    input wire logic buf_wr_en,
    input wire logic [CNT_W-1:0] buf_wr_addr,
    input wire logic [7:0] buf_wr_data,
    input wire logic sample_end
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Accesses to the configuration byte
    wire cfg_wr = req.wr && req.addr == ioec_pkg::CFG_OFFS;
    wire cfg_rd = req.rd && req.addr == ioec_pkg::CFG_OFFS;
    // Overrun seen, then read again with no write between
    sequence ovr_reread;
        cfg_rd ##1 (rdata[5] && !req.wr) ##1 (cfg_rd && !req.wr);
    endsequence
    chk_enable_gate: assert property (cfg_wr && !req.wdata[7] |=> !iso_active && !noniso_active)
        else $error("active while off");
    chk_idle_drop: assert property (in_byte.valid && !iso_active |=> !buf_wr_en)
        else $error("byte taken while idle");
    chk_mode_select: assert property (cfg_wr && req.wdata[7] |=>
        iso_active == $past(req.wdata[6]) && noniso_active != $past(req.wdata[6]))
        else $error("mode wrong");
    chk_size_code: assert property (cfg_wr |=>
        sample_bytes == {1'b0, $past(req.wdata[4:0])} + 6'h01)
        else $error("size code wrong");
    chk_ovr_sticky: assert property (ovr_reread |=> rdata[5])
        else $error("overrun cleared");
    chk_mode_hold: assert property (!req.wr |=> $stable({iso_active, noniso_active}))
        else $error("mode moved");
    chk_first_byte: assert property (in_byte.valid && in_byte.pkt_start && iso_active |=>
        buf_wr_en && buf_wr_addr == '0 && buf_wr_data == $past(in_byte.data))
        else $error("first byte lost");
    chk_sample_end: assert property (sample_end |-> buf_wr_en)
        else $error("sample end alone");
endmodule : ioec_endpoint_chk

bind ioec_endpoint ioec_endpoint_chk #(.CNT_W(CNT_W)) chk (.clk, .rst, .req, .rdata, .in_byte,
    .iso_active, .noniso_active, .sample_bytes, .buf_wr_en, .buf_wr_addr, .buf_wr_data,
    .sample_end);

// ==== tb/ioec_host_model.sv ====
// Host side: sends one OUT packet of len bytes after a go pulse.
// Assumes go is a one-cycle pulse on the same clock.
module ioec_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] len,
    output ioec_pkg::ioec_byte_type out_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left_ff = 8'h00;
    logic [7:0] seq_ff = 8'h00;
    wire busy = go || left_ff != 8'h00;
    initial out_byte = '0;
    // Data toggles between packets so a stale byte never looks fresh
    always @(posedge clk) begin
        seq_ff <= seq_ff + 8'h01;
        out_byte <= '{busy ? seq_ff : ~seq_ff, busy, go};
        left_ff <= go ? len - 8'h01 : left_ff - {7'h00, left_ff != 8'h00};
    end
endmodule : ioec_host_model

// ==== tb/ioec_endpoint_bench.sv ====
// Bench for the out endpoint configuration byte.
// Assumes the host model feeds bytes; the bench owns the register port.
module ioec_endpoint_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [7:0] len = 8'h04;
    ioec_pkg::ioec_req_type req = '0;
    ioec_pkg::ioec_byte_type in_byte;
    logic [7:0] rdata;
    logic iso_active;
    logic noniso_active;
    logic [5:0] sample_bytes;
    logic buf_wr_en;
    logic [7:0] buf_wr_addr;
    logic [7:0] buf_wr_data;
    logic [7:0] last_data = 8'h00;
    logic sample_end;
    logic [7:0] v;
    logic [7:0] modes [5] = '{8'h80, 8'h40, 8'hC0, 8'hDF, 8'h1F};
    int error_cnt = 0;
    int n_checks = 0;
    int wr_cnt = 0;
    int end_cnt = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    ioec_host_model host (.clk, .go, .len, .out_byte(in_byte));
    ioec_endpoint #(.CNT_W(8)) uut (.clk, .rst, .req, .rdata, .in_byte, .iso_active,
        .noniso_active, .sample_bytes, .buf_wr_en, .buf_wr_addr, .buf_wr_data, .sample_end);
    // Count accepted bytes and sample ends; cut a hang short
    always @(posedge clk) begin
        // Each buffer write carries the byte of the cycle before, at the next index
        if (buf_wr_en === 1'b1) begin
            cmp("wr_addr", 8'(wr_cnt), buf_wr_addr);
            cmp("wr_data", last_data, buf_wr_data);
        end
        last_data <= in_byte.data;
        wr_cnt += int'(buf_wr_en === 1'b1);
        end_cnt += int'(sample_end === 1'b1);
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    task cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : cmp
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
        #1 cmp(nm, exp, rdata);
    endtask : rd
    task send;
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : send
    task results;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 8'h00, "cfg");
        rd(4'h2, 8'h80, "limit");
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00, "unmapped");
        // Enable and mode pairs, size field at both ends
        foreach (modes[i]) begin
            v = modes[i];
            wr(4'h0, v);
            #1 cmp("iso", {7'h00, v[7] & v[6]}, {7'h00, iso_active});
            cmp("noniso", {7'h00, v[7] & ~v[6]}, {7'h00, noniso_active});
            cmp("size", {3'h0, v[4:0]} + 8'h01, {2'h0, sample_bytes});
        end
        // Two-byte buffer, two-byte samples, four-byte packet
        wr(4'h0, 8'hC1);
        wr(4'h2, 8'h02);
        send();
        cmp("taken", 8'h02, 8'(wr_cnt));
        cmp("samples", 8'h01, 8'(end_cnt));
        rd(4'h1, 8'h04, "seen");
        rd(4'h0, 8'hE1, "overrun");
        rd(4'h0, 8'hE1, "sticky");
        wr(4'h0, 8'hC1);
        rd(4'h0, 8'hC1, "cleared");
        // Enable off: the packet is ignored
        wr(4'h0, 8'h41);
        send();
        cmp("ignored", 8'h02, 8'(wr_cnt));
        rd(4'h1, 8'h00, "seen off");
        results();
    end
endmodule : ioec_endpoint_bench
